// ### design/rmoc_ctrl.sv
// ratio and output control: range detector, ratio modifiers, output gating, register slave
// assumes sys_clk is the internal reference clock; pins and synthesizer signals are asynchronous
`timescale 1ns/1ps
module rmoc_ctrl (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // mode pins
    input  wire logic [1:0]  set_select,
    input  wire logic        function_pin,
    // reference input and synthesizer side
    input  wire logic        ref_clk_in,
    input  wire logic        synth_clk,
    input  wire logic        synth_locked,
    output logic      [31:0] effective_ratio,
    output logic             ratio_format,
    output logic      [1:0]  input_range_code,
    // output pin drive
    output rmoc_pkg::rmoc_drive_t drive
);
    // configuration registers
    logic [31:0]           ratio_q [rmoc_pkg::NUM_SETS];
    rmoc_pkg::rmoc_modal_t modal_q [rmoc_pkg::NUM_SETS];
    rmoc_pkg::rmoc_global_t glb_q;
    logic                  ack_q;
    logic [31:0]           rdat_q;
    // range detector state
    logic [7:0]            per_q;
    logic [1:0]            range_q;
    logic                  ref_d1_q;
    // outputs
    logic [31:0]           eff_q;
    rmoc_pkg::rmoc_drive_t drv_q;

    // pin synchronisers: set[1:0], function pin, reference, synth clock, lock
    logic [5:0] sync_lvl;
    rmoc_sync #(.W(6)) u_sync (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .async_in ({set_select, function_pin, ref_clk_in, synth_clk, synth_locked}),
        .level    (sync_lvl)
    );
    wire logic [1:0] set_f   = sync_lvl[5:4];
    wire logic       fp_f    = sync_lvl[3];
    wire logic       ref_f   = sync_lvl[2];
    wire logic       syn_f   = sync_lvl[1];
    wire logic       lock_f  = sync_lvl[0];

    // bus decode
    wire logic       req     = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic       wr      = req && wb_we_i;
    wire logic       hit_rat = (wb_adr_i[7:4] == rmoc_pkg::OFF_RATIO0[7:4]) && (wb_adr_i[1:0] == 2'h0);
    wire logic       hit_mod = (wb_adr_i[7:4] == rmoc_pkg::OFF_MODAL0[7:4]) && (wb_adr_i[1:0] == 2'h0);
    wire logic       hit_glb = (wb_adr_i == rmoc_pkg::OFF_GLOBAL);
    wire logic [1:0] widx    = wb_adr_i[3:2];
    wire logic [31:0] bmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // active set selected by the pins
    wire rmoc_pkg::rmoc_modal_t act_set = modal_q[set_f];
    wire logic [31:0]           ratio_sel = ratio_q[set_f];
    wire logic [2:0]            pf        = glb_q.pin_function_selection;

    // modifier enables
    wire logic man_en  = (pf == rmoc_pkg::PF_MAN_EN) && fp_f;
    wire logic auto_en = (pf == rmoc_pkg::PF_AUTO_EN) ? fp_f
                                                      : act_set.auto_modifier_enable;
    // shifts: manual 1..4, automatic 0..2; code 11 treated as quarter
    wire logic [2:0] man_sh  = man_en ? ({1'b0, act_set.manual_modifier_select} + 3'h1) : 3'h0;
    wire logic [2:0] auto_sh = !auto_en ? 3'h0 :
                               (range_q == rmoc_pkg::RC_HIGH) ? 3'h0 :
                               (range_q == rmoc_pkg::RC_MID)  ? 3'h1 : 3'h2;
    wire logic [2:0] tot_sh  = man_sh + auto_sh;
    // scaling on a copy; the stored ratio is only read here
    wire logic [31:0] eff_d  = ratio_sel >> tot_sh;

    // output disables from the function pin, low enables and high disables
    wire logic main_dis = fp_f && ((pf == rmoc_pkg::PF_MAIN_DIS) || (pf == rmoc_pkg::PF_BOTH_DIS));
    wire logic aux_dis  = fp_f && ((pf == rmoc_pkg::PF_AUX_DIS) || (pf == rmoc_pkg::PF_BOTH_DIS));
    wire logic aux_force_syn = fp_f && (pf == rmoc_pkg::PF_AUX_SYN);
    wire logic [1:0] aux_src = aux_force_syn ? rmoc_pkg::AUX_SYN : act_set.auxiliary_source_select;

    // main output: held low while unlocked unless told to run on
    wire logic main_val = (lock_f || glb_q.output_on_unlock) ? syn_f : 1'b0;
    // auxiliary mux and lock indicator driver
    wire logic od_mode  = (aux_src == rmoc_pkg::AUX_LOCK) && glb_q.lock_indicator_config;
    wire logic aux_val  = (aux_src == rmoc_pkg::AUX_REF)  ? ref_f :
                          (aux_src == rmoc_pkg::AUX_SYN)  ? syn_f :
                          (aux_src == rmoc_pkg::AUX_LOCK) ? (!glb_q.lock_indicator_config && !lock_f) :
                          1'b0;
    // reserved source leaves the pin undriven
    wire logic aux_on   = !aux_dis && (aux_src != 2'h0) && (!od_mode || !lock_f);
    wire rmoc_pkg::rmoc_drive_t drv_d = '{main_out: main_val && !main_dis,
                                          main_oe:  !main_dis,
                                          aux_out:  aux_val && aux_on,
                                          aux_oe:   aux_on};

    // range detector: input period in reference cycles, saturating
    wire logic ref_rise = ref_f && !ref_d1_q;
    wire logic [7:0] per_d = ref_rise ? 8'h01 : ((per_q == rmoc_pkg::PER_MAX) ? per_q : per_q + 8'h01);
    wire logic [1:0] range_d = (ref_rise && (per_q < rmoc_pkg::RANGE_LO)) ? rmoc_pkg::RC_LOW :
                               (ref_rise && (per_q <= rmoc_pkg::RANGE_HI)) ? rmoc_pkg::RC_MID :
                               (per_q > rmoc_pkg::RANGE_HI) ? rmoc_pkg::RC_HIGH : range_q;

    // read mux
    wire logic [31:0] rd_d = hit_rat ? ratio_q[widx] :
                             hit_mod ? {27'h0, modal_q[widx]} :
                             hit_glb ? {26'h0, glb_q} :
                             (wb_adr_i == rmoc_pkg::OFF_STATUS) ? {26'h0, fp_f, set_f, lock_f, range_q} :
                             (wb_adr_i == rmoc_pkg::OFF_EFFECT) ? eff_q : 32'h0;

    // bus handshake: one ack per request, then released
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end
        else
        begin
            ack_q  <= req;
            rdat_q <= req ? rd_d : rdat_q;
        end
    end

    // configuration writes with byte enables; unmapped writes are dropped
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < rmoc_pkg::NUM_SETS; i++)
            begin
                ratio_q[i] <= rmoc_pkg::RATIO_RST;
                modal_q[i] <= rmoc_pkg::MODAL_RST;
            end
            glb_q <= rmoc_pkg::GLOBAL_RST;
        end
        else
        begin
            if (wr && hit_rat)
            begin
                ratio_q[widx] <= (ratio_q[widx] & ~bmask) | (wb_dat_i & bmask);
            end
            if (wr && hit_mod && wb_sel_i[0])
            begin
                modal_q[widx] <= wb_dat_i[4:0];
            end
            if (wr && hit_glb && wb_sel_i[0])
            begin
                glb_q <= wb_dat_i[5:0];
            end
        end
    end

    // range detector and registered outputs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            per_q    <= 8'h00;
            range_q  <= rmoc_pkg::RC_HIGH;
            ref_d1_q <= 1'b0;
            eff_q    <= 32'h0;
            drv_q    <= '0;
        end
        else
        begin
            per_q    <= per_d;
            range_q  <= range_d;
            ref_d1_q <= ref_f;
            eff_q    <= eff_d;
            drv_q    <= drv_d;
        end
    end

    assign wb_ack_o         = ack_q;
    assign wb_dat_o         = rdat_q;
    assign effective_ratio  = eff_q;
    assign ratio_format     = glb_q.ratio_format_select;
    assign input_range_code = range_q;
    assign drive            = drv_q;

    // checks
    property p_range_hi;
        @(posedge sys_clk) disable iff (!rstn)
        (per_q > rmoc_pkg::RANGE_HI) |=> (range_q == rmoc_pkg::RC_HIGH);
    endproperty
    a_range_hi: assert property (p_range_hi) else $error("range code not 00 above 224");

    property p_range_lo;
        @(posedge sys_clk) disable iff (!rstn)
        (ref_rise && per_q < rmoc_pkg::RANGE_LO) |=> (range_q == rmoc_pkg::RC_LOW) [*1];
    endproperty
    a_range_lo: assert property (p_range_lo) else $error("range code not 10 below 96");

    property p_no_code11;
        @(posedge sys_clk) disable iff (!rstn)
        range_q != 2'h3;
    endproperty
    a_no_code11: assert property (p_no_code11) else $error("range code 11 produced");

    property p_eff_ratio;
        @(posedge sys_clk) disable iff (!rstn)
        (!man_en && auto_en && range_q == rmoc_pkg::RC_MID) |=> (eff_q == ($past(ratio_sel) >> 1));
    endproperty
    a_eff_ratio: assert property (p_eff_ratio) else $error("auto half not applied");

    property p_manual_pin;
        @(posedge sys_clk) disable iff (!rstn)
        (pf != rmoc_pkg::PF_MAN_EN && !auto_en) |=> (eff_q == $past(ratio_sel));
    endproperty
    a_manual_pin: assert property (p_manual_pin) else $error("ratio scaled without enables");

    property p_ratio_kept;
        @(posedge sys_clk) disable iff (!rstn)
        !(wr && hit_rat) |=> $stable(ratio_q[0]) && $stable(ratio_q[1]) && $stable(ratio_q[2]) && $stable(ratio_q[3]);
    endproperty
    a_ratio_kept: assert property (p_ratio_kept) else $error("stored ratio changed");

    property p_main_low;
        @(posedge sys_clk) disable iff (!rstn)
        (!lock_f && !glb_q.output_on_unlock) |=> !drive.main_out;
    endproperty
    a_main_low: assert property (p_main_low) else $error("main output runs while unlocked");

    property p_main_dis;
        @(posedge sys_clk) disable iff (!rstn)
        (fp_f && pf == rmoc_pkg::PF_BOTH_DIS) |=> !drive.main_oe && !drive.aux_oe;
    endproperty
    a_main_dis: assert property (p_main_dis) else $error("outputs not floated");

    property p_lock_od;
        @(posedge sys_clk) disable iff (!rstn)
        (aux_src == rmoc_pkg::AUX_LOCK && glb_q.lock_indicator_config && !aux_dis && !lock_f)
            |=> drive.aux_oe && !drive.aux_out;
    endproperty
    a_lock_od: assert property (p_lock_od) else $error("open drain indicator not pulling low");

    property p_ack_once;
        @(posedge sys_clk) disable iff (!rstn)
        req |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not single cycle");
endmodule : rmoc_ctrl

// ### design/rmoc_pkg.sv
// constants, register map and carrier types of the ratio and output control block
// assumes a 40 MHz sys_clk serving as the internal reference clock and a classic Wishbone master
package rmoc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_RATIO0  = 8'h00;
    localparam logic [7:0] OFF_MODAL0  = 8'h10;
    localparam logic [7:0] OFF_GLOBAL  = 8'h20;
    localparam logic [7:0] OFF_STATUS  = 8'h24;
    localparam logic [7:0] OFF_EFFECT  = 8'h28;
    localparam int         NUM_SETS    = 4;
    // range detector thresholds and counter
    localparam int         PER_W       = 8;
    localparam logic [7:0] RANGE_HI    = 8'he0;  // 224
    localparam logic [7:0] RANGE_LO    = 8'h60;  // 96
    localparam logic [7:0] PER_MAX     = 8'hff;
    // range codes
    localparam logic [1:0] RC_HIGH     = 2'h0;
    localparam logic [1:0] RC_MID      = 2'h1;
    localparam logic [1:0] RC_LOW      = 2'h2;
    // pin function codes
    localparam logic [2:0] PF_MAIN_DIS = 3'h0;
    localparam logic [2:0] PF_AUX_DIS  = 3'h1;
    localparam logic [2:0] PF_BOTH_DIS = 3'h2;
    localparam logic [2:0] PF_MAN_EN   = 3'h3;
    localparam logic [2:0] PF_AUTO_EN  = 3'h5;
    localparam logic [2:0] PF_AUX_SYN  = 3'h7;
    // auxiliary source codes
    localparam logic [1:0] AUX_REF     = 2'h1;
    localparam logic [1:0] AUX_SYN     = 2'h2;
    localparam logic [1:0] AUX_LOCK    = 2'h3;
    // reset values
    localparam logic [31:0] RATIO_RST  = 32'h0000_0000;
    localparam logic [4:0]  MODAL_RST  = 5'h00;
    localparam logic [5:0]  GLOBAL_RST = 6'h00;

    // one modal set, bit layout of a modal register
    typedef struct packed {
        logic       auto_modifier_enable;     // bit 4
        logic [1:0] auxiliary_source_select;  // bits 3:2
        logic [1:0] manual_modifier_select;   // bits 1:0
    } rmoc_modal_t;

    // global parameters, bit layout of the global register
    typedef struct packed {
        logic       ratio_format_select;      // bit 5
        logic       lock_indicator_config;    // bit 4
        logic       output_on_unlock;         // bit 3
        logic [2:0] pin_function_selection;   // bits 2:0
    } rmoc_global_t;

    // pin drive of both clock outputs
    typedef struct packed {
        logic main_out;
        logic main_oe;
        logic aux_out;
        logic aux_oe;
    } rmoc_drive_t;
endpackage : rmoc_pkg

// ### design/rmoc_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
// assumes inputs asynchronous to sys_clk; output settles four edges after a stable change
`timescale 1ns/1ps
module rmoc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // pins and filtered level
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // a change is taken only when stages two and three agree
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            level <= '0;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++)
            begin
                if (s2_q[i] == s3_q[i])
                begin
                    level[i] <= s3_q[i];
                end
            end
        end
    end
endmodule : rmoc_sync

// ### bench/rmoc_partner.sv
// far side model: jittery reference source, synthesizer clock and lock line
// assumes the bench picks the reference half period and the lock state
`timescale 1ns/1ps
module rmoc_partner (
    // period choice and lock request from the bench
    input  wire logic [15:0] ref_half_ns,
    input  wire logic        lock_req,
    // clocks and lock towards the block
    output logic             ref_clk_in,
    output logic             synth_clk,
    output logic             synth_locked
);
    // reference wobbles by up to one sys_clk per half period, far from the range thresholds
    initial
    begin
        ref_clk_in = 1'b0;
        forever
        begin
            #(ref_half_ns + $urandom_range(0, 25));
            ref_clk_in = ~ref_clk_in;
        end
    end
    // synthesizer clock slow enough to survive pin sampling
    initial
    begin
        synth_clk = 1'b0;
        forever
        begin
            #100;
            synth_clk = ~synth_clk;
        end
    end
    assign synth_locked = lock_req;
endmodule : rmoc_partner

// ### bench/tb_top.sv
// self-checking bench of the ratio and output control block against a behavioural model
// assumes the partner supplies clocks and lock; the bench drives the bus and the mode pins
`timescale 1ns/1ps
module tb_top;
    logic                  sys_clk, rstn, wb_cyc, wb_stb, wb_we, wb_ack_o;
    logic [7:0]            wb_adr;
    logic [3:0]            wb_sel;
    logic [31:0]           wb_dat, wb_dat_o, effective_ratio, rd;
    logic                  ratio_format, synth_clk, synth_locked, ref_clk_in, function_pin, lock_req;
    logic [1:0]            set_select, input_range_code;
    logic [15:0]           ref_half_ns;
    rmoc_pkg::rmoc_drive_t drive;
    int                    failures, check_count, rc, pf, pin, s, lk, g, src, hi, a_off;
    logic [31:0]           ratio [4];
    logic [4:0]            modal [4];
    int                    pf_tbl [6] = '{0, 1, 2, 3, 5, 7};
    int                    half_tbl [3] = '{3750, 2000, 500};

    rmoc_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .set_select(set_select), .function_pin(function_pin), .ref_clk_in(ref_clk_in),
        .synth_clk(synth_clk), .synth_locked(synth_locked), .effective_ratio(effective_ratio),
        .ratio_format(ratio_format), .input_range_code(input_range_code), .drive(drive));
    rmoc_partner far_side (.ref_half_ns(ref_half_ns), .lock_req(lock_req), .ref_clk_in(ref_clk_in),
        .synth_clk(synth_clk), .synth_locked(synth_locked));

    // 40 MHz system clock
    always #12.5 sys_clk = ~sys_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // one classic cycle; entered just after a rising edge, waits for ack with no bound of its own
    // a slave that never answers is caught by the watchdog, not here
    task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= w;
        wb_sel <= 4'hf;
        wb_adr <= a;
        wb_dat <= d;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge sys_clk);
        end
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge sys_clk);
    endtask : wb_xfer

    // expected effective ratio: manual shift only via the pin, auto shift by range
    function automatic logic [31:0] model_eff(input int s, input int pf, input int pin, input int rc);
        int sh;
        int auto_en;
        sh = (pf == 3 && pin == 1) ? modal[s][1:0] + 1 : 0;
        auto_en = (pf == 5) ? pin : modal[s][4];
        if (auto_en == 1)
            sh = sh + ((rc == 0) ? 0 : (rc == 1) ? 1 : 2);
        return ratio[s] >> sh;
    endfunction : model_eff

    // hang guard, far beyond the expected few thousand cycles
    initial
    begin
        #(25 * 20000);
        failures++;
        tally_and_finish();
    end

    // reset, register checks, then a sweep over range codes, pin functions and pin levels
    initial
    begin
        {sys_clk, rstn, wb_cyc, wb_stb, wb_we, function_pin, lock_req} = 7'h00;
        {wb_adr, wb_dat, set_select} = 42'h0;
        wb_sel = 4'hf;
        ref_half_ns = 16'd3750;
        void'($urandom(12));
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        foreach (pf_tbl[k])
        begin
            wb_xfer(8'(k * 8), 1'b0, 32'h0, rd);
            check(rd, 32'h0);
        end
        wb_xfer(8'h30, 1'b1, 32'hffff_ffff, rd);
        wb_xfer(8'h30, 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            ratio[k] = $urandom() & 32'hffff_ffc0;
            modal[k] = 5'($urandom());
            wb_xfer(8'(4 * k), 1'b1, ratio[k], rd);
            wb_xfer(8'(16 + 4 * k), 1'b1, {27'h0, modal[k]}, rd);
            wb_xfer(8'(16 + 4 * k), 1'b0, 32'h0, rd);
            check(rd, {27'h0, modal[k]});
        end
        for (int i = 0; i < 36; i++)
        begin
            rc = i / 12;
            if (i % 12 == 0)
            begin
                ref_half_ns <= 16'(half_tbl[rc]);
                repeat (1000) @(posedge sys_clk);
            end
            pf = pf_tbl[(i / 2) % 6];
            pin = i % 2;
            s = $urandom_range(0, 3);
            lk = $urandom_range(0, 1);
            g = $urandom_range(0, 7);
            wb_xfer(8'h20, 1'b1, {26'h0, 3'(g), 3'(pf)}, rd);
            set_select <= 2'(s);
            function_pin <= 1'(pin);
            lock_req <= 1'(lk);
            repeat (10) @(posedge sys_clk);
            check(effective_ratio, model_eff(s, pf, pin, rc));
            check({30'h0, input_range_code}, 32'(rc));
            check({31'h0, ratio_format}, 32'(g / 4));
            src = (pf == 7 && pin == 1) ? 2 : modal[s][3:2];
            a_off = (pin == 1 && (pf == 1 || pf == 2)) ? 1 : 0;
            check({31'h0, drive.main_oe}, (pin == 1 && (pf == 0 || pf == 2)) ? 0 : 1);
            check({31'h0, drive.aux_oe}, (a_off == 1 || src == 0) ? 0 : (src == 3 && g[1]) ? !lk : 1);
            if (a_off == 0 && src == 3)
                check({31'h0, drive.aux_out}, g[1] ? 0 : !lk);
            hi = 0;
            repeat (16)
            begin
                @(posedge sys_clk);
                hi += (drive.main_out === 1'b1) ? 1 : 0;
            end
            check(32'(hi > 0), 32'((lk == 1 || g[0]) && !(pin == 1 && (pf == 0 || pf == 2))));
            wb_xfer({4'h0, 2'(s), 2'h0}, 1'b0, 32'h0, rd);
            check(rd, ratio[s]);
            wb_xfer(8'h24, 1'b0, 32'h0, rd);
            check(rd, {26'h0, 1'(pin), 2'(s), 1'(lk), 2'(rc)});
        end
        tally_and_finish();
    end
endmodule : tb_top
